//--- pio6_pkg.sv
// package of constants and types for the eight-pin general i/o port
// Operation
// - outside 16-bit bus mode, direction one drives pin, zero makes input
// - in 16-bit extended mode pins are data bus lines regardless of direction
// - 16-bit mode read: stored data where direction one, else one
// - other modes read: stored data where direction one, else live pin
// - data register holds output values, readable and writable
// - pull-up bit enables pull-up on input pins, ignored in 16-bit mode
// - pull-up register accessible only while keyboard wake-up enable is one
// - system control two bit 5 selects standard or current-limited pull-up
// - system control two bit 3 selects normal or multiplexed extended bus
// - port is eight pins, lower data bus byte in extended mode
// - direction register write-only, resets to zero so pins start as inputs
// - outside 16-bit mode, filter-enabled pins load the sample into data register at an interval when two samples agree
// - interval codes 0 to 4 divide clock by 2, 32, 512, 8192, 32768
package pio6_pkg;
  localparam int PIO6_WIDTH = 8;
  localparam int PIO6_CNT_W = 15;
  // ============================================================
  // register offsets
  localparam logic [2:0] PIO6_OFF_DIR = 3'h0;
  localparam logic [2:0] PIO6_OFF_DATA = 3'h1;
  localparam logic [2:0] PIO6_OFF_PULLUP = 3'h2;
  localparam logic [2:0] PIO6_OFF_SYSCTL2 = 3'h3;
  localparam logic [2:0] PIO6_OFF_FILT_EN = 3'h4;
  localparam logic [2:0] PIO6_OFF_FILT_SEL = 3'h5;
  // ============================================================
  // reset values and fields
  localparam logic [7:0] PIO6_RST_BYTE = 8'h00;
  localparam logic [7:0] PIO6_ALL_ONES = 8'hFF;
  localparam logic [2:0] PIO6_RST_SEL = 3'h0;
  localparam int PIO6_BIT_PU_CURRENT = 5;
  localparam int PIO6_BIT_MUX_BUS = 3;
  // ============================================================
  // filter interval codes and divides
  localparam logic [2:0] PIO6_SEL_D2 = 3'h0;
  localparam logic [2:0] PIO6_SEL_D32 = 3'h1;
  localparam logic [2:0] PIO6_SEL_D512 = 3'h2;
  localparam logic [2:0] PIO6_SEL_D8192 = 3'h3;
  localparam logic [2:0] PIO6_SEL_D32768 = 3'h4;
  localparam int PIO6_DIV_2 = 2;
  localparam int PIO6_DIV_32 = 32;
  localparam int PIO6_DIV_512 = 512;
  localparam int PIO6_DIV_8192 = 8192;
  localparam int PIO6_DIV_32768 = 32768;
  // ============================================================
  // register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pio6_bus_req_t;
endpackage

//--- pio6_filter.sv
// one pin: two-flop synchroniser and interval sampler
`timescale 1ns/1ps
module pio6_filter (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  input wire logic tick_in,
  output logic level_out,
  output logic stable_out,
  output logic sample_out
);
  logic sync_a;
  logic sync_b;
  logic samp_new;
  logic samp_old;
  logic next_sync_a;
  logic next_sync_b;
  logic next_samp_new;
  logic next_samp_old;

  always_comb begin
    next_sync_a = pin_in;
    next_sync_b = sync_a;
    next_samp_new = samp_new;
    next_samp_old = samp_old;
    if (tick_in) begin
      next_samp_new = sync_b;
      next_samp_old = samp_new;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      samp_new <= 1'b0;
      samp_old <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      samp_new <= next_samp_new;
      samp_old <= next_samp_old;
    end
  end

  assign level_out = sync_b;
  // two equal samples in a row count as stable
  assign stable_out = (samp_new == samp_old);
  assign sample_out = samp_new;
endmodule

//--- pio6_port.sv
// eight-pin general i/o port with pull-ups, bus mode and input filter
`timescale 1ns/1ps
module pio6_port #(
  parameter int DIV_8192 = pio6_pkg::PIO6_DIV_8192,
  parameter int DIV_32768 = pio6_pkg::PIO6_DIV_32768
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire pio6_pkg::pio6_bus_req_t bus_req_in,
  output logic [7:0] rdata_out,
  input wire logic ext16_mode_in,
  input wire logic keyboard_wakeup_enable_in,
  input wire logic [7:0] ext_bus_wdata_in,
  input wire logic ext_bus_drive_in,
  output logic [7:0] ext_bus_rdata_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_b_out,
  output logic [7:0] pullup_on_out,
  output logic pullup_current_select_out,
  output logic muxed_bus_enable_out
);
  import pio6_pkg::*;

  // ============================================================
  // registers
  logic [7:0] port_direction;
  logic [7:0] port_output_data;
  logic [7:0] pullup_enable;
  logic [7:0] system_control_two;
  logic [7:0] filter_enable;
  logic [2:0] filter_interval_select;
  logic [7:0] next_port_direction;
  logic [7:0] next_port_output_data;
  logic [7:0] next_pullup_enable;
  logic [7:0] next_system_control_two;
  logic [7:0] next_filter_enable;
  logic [2:0] next_filter_interval_select;
  logic [7:0] pin_level;
  logic [7:0] filt_stable;
  logic [7:0] filt_sample;
  logic [7:0] sample_load;
  logic wr_dir;
  logic wr_data;
  logic wr_pullup;
  logic wr_sysctl;
  logic wr_filt_en;
  logic wr_filt_sel;
  logic tick;

  assign wr_dir = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_DIR);
  assign wr_data = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_DATA);
  // pull-up register locked unless wake-up enable set
  assign wr_pullup = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_PULLUP) && keyboard_wakeup_enable_in;
  assign wr_sysctl = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_SYSCTL2);
  assign wr_filt_en = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_FILT_EN);
  assign wr_filt_sel = bus_req_in.wr && (bus_req_in.addr == PIO6_OFF_FILT_SEL);

  // filtered sample loads data register, outside 16-bit mode only
  assign sample_load = (tick && !ext16_mode_in) ? (filter_enable & filt_stable) : PIO6_RST_BYTE;

  always_comb begin
    next_port_direction = wr_dir ? bus_req_in.wdata : port_direction;
    // software write takes priority over a filter sample
    next_port_output_data = (port_output_data & ~sample_load) | (filt_sample & sample_load);
    if (wr_data) begin
      next_port_output_data = bus_req_in.wdata;
    end
    next_pullup_enable = wr_pullup ? bus_req_in.wdata : pullup_enable;
    next_system_control_two = wr_sysctl ? bus_req_in.wdata : system_control_two;
    next_filter_enable = wr_filt_en ? bus_req_in.wdata : filter_enable;
    next_filter_interval_select = wr_filt_sel ? bus_req_in.wdata[2:0] : filter_interval_select;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      port_direction <= PIO6_RST_BYTE;
      port_output_data <= PIO6_RST_BYTE;
      pullup_enable <= PIO6_RST_BYTE;
      system_control_two <= PIO6_RST_BYTE;
      filter_enable <= PIO6_RST_BYTE;
      filter_interval_select <= PIO6_RST_SEL;
    end else begin
      port_direction <= next_port_direction;
      port_output_data <= next_port_output_data;
      pullup_enable <= next_pullup_enable;
      system_control_two <= next_system_control_two;
      filter_enable <= next_filter_enable;
      filter_interval_select <= next_filter_interval_select;
    end
  end

  // ============================================================
  // sampling interval prescaler
  logic [PIO6_CNT_W-1:0] div_cnt;
  logic [PIO6_CNT_W-1:0] next_div_cnt;
  logic [PIO6_CNT_W-1:0] div_max;

  always_comb begin
    case (filter_interval_select)
      PIO6_SEL_D2: div_max = PIO6_CNT_W'(PIO6_DIV_2 - 1);
      PIO6_SEL_D32: div_max = PIO6_CNT_W'(PIO6_DIV_32 - 1);
      PIO6_SEL_D512: div_max = PIO6_CNT_W'(PIO6_DIV_512 - 1);
      PIO6_SEL_D8192: div_max = PIO6_CNT_W'(DIV_8192 - 1);
      PIO6_SEL_D32768: div_max = PIO6_CNT_W'(DIV_32768 - 1);
      default: div_max = PIO6_CNT_W'(DIV_32768 - 1);
    endcase
  end

  assign tick = (div_cnt >= div_max);

  always_comb begin
    next_div_cnt = tick ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ============================================================
  // per-pin synchroniser and sampler
  genvar gi;
  generate
    for (gi = 0; gi < PIO6_WIDTH; gi++) begin : g_pin
      pio6_filter u_filter (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(pin_in[gi]),
        .tick_in(tick),
        .level_out(pin_level[gi]),
        .stable_out(filt_stable[gi]),
        .sample_out(filt_sample[gi])
      );
    end
  endgenerate

  // ============================================================
  // read path
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = PIO6_RST_BYTE;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        PIO6_OFF_DIR: next_rdata = PIO6_RST_BYTE;
        PIO6_OFF_DATA: begin
          if (ext16_mode_in) begin
            next_rdata = (port_output_data & port_direction) | ~port_direction;
          end else begin
            next_rdata = (port_output_data & port_direction) | (pin_level & ~port_direction);
          end
        end
        PIO6_OFF_PULLUP: next_rdata = keyboard_wakeup_enable_in ? pullup_enable : PIO6_RST_BYTE;
        PIO6_OFF_SYSCTL2: next_rdata = system_control_two;
        PIO6_OFF_FILT_EN: next_rdata = filter_enable;
        PIO6_OFF_FILT_SEL: next_rdata = {5'h00, filter_interval_select};
        default: next_rdata = PIO6_RST_BYTE;
      endcase
    end
  end

  // ============================================================
  // pin drive and pull-up outputs
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe_b;
  logic [7:0] next_pullup_on;
  logic [7:0] next_ext_bus_rdata;

  always_comb begin
    if (ext16_mode_in) begin
      // pins act as low data byte of the external bus
      next_pin_out = ext_bus_wdata_in;
      next_pin_oe_b = ext_bus_drive_in ? PIO6_RST_BYTE : PIO6_ALL_ONES;
      next_pullup_on = PIO6_RST_BYTE;
    end else begin
      next_pin_out = port_output_data;
      next_pin_oe_b = ~port_direction;
      next_pullup_on = pullup_enable & ~port_direction;
    end
    next_ext_bus_rdata = pin_level;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= PIO6_RST_BYTE;
      pin_out <= PIO6_RST_BYTE;
      pin_oe_b_out <= PIO6_ALL_ONES;
      pullup_on_out <= PIO6_RST_BYTE;
      ext_bus_rdata_out <= PIO6_RST_BYTE;
      pullup_current_select_out <= 1'b0;
      muxed_bus_enable_out <= 1'b0;
    end else begin
      rdata_out <= next_rdata;
      pin_out <= next_pin_out;
      pin_oe_b_out <= next_pin_oe_b;
      pullup_on_out <= next_pullup_on;
      ext_bus_rdata_out <= next_ext_bus_rdata;
      pullup_current_select_out <= next_system_control_two[PIO6_BIT_PU_CURRENT];
      muxed_bus_enable_out <= next_system_control_two[PIO6_BIT_MUX_BUS];
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic past_valid;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  chk_dir_drives_pin: assert property (
    past_valid && !$past(ext16_mode_in) |-> pin_oe_b_out == ~$past(port_direction))
    else $error("pin enable does not follow direction");

  chk_bus_mode_pins: assert property (
    ext16_mode_in && ext_bus_drive_in |=> pin_oe_b_out == PIO6_RST_BYTE && pin_out == $past(ext_bus_wdata_in))
    else $error("bus mode pins not driven by bus");

  chk_read_bus_mode: assert property (
    bus_req_in.rd && bus_req_in.addr == PIO6_OFF_DATA && ext16_mode_in
    |=> rdata_out == (($past(port_output_data) & $past(port_direction)) | ~$past(port_direction)))
    else $error("bus mode port read wrong");

  chk_read_pin_mode: assert property (
    bus_req_in.rd && bus_req_in.addr == PIO6_OFF_DATA && !ext16_mode_in
    |=> rdata_out == (($past(port_output_data) & $past(port_direction)) | ($past(pin_level) & ~$past(port_direction))))
    else $error("port read wrong");

  chk_data_write: assert property (
    wr_data
    |=> port_output_data == $past(bus_req_in.wdata))
    else $error("data register write lost");

  chk_pullup_bus_off: assert property (
    ext16_mode_in |=> pullup_on_out == PIO6_RST_BYTE)
    else $error("pull-up active in bus mode");

  chk_pullup_locked: assert property (
    bus_req_in.wr && bus_req_in.addr == PIO6_OFF_PULLUP && !keyboard_wakeup_enable_in |=> $stable(pullup_enable))
    else $error("locked pull-up register changed");

  chk_current_select: assert property (
    wr_sysctl |=> pullup_current_select_out == $past(bus_req_in.wdata[PIO6_BIT_PU_CURRENT]))
    else $error("current select not taken");

  chk_mux_select: assert property (
    wr_sysctl |=> muxed_bus_enable_out == $past(bus_req_in.wdata[PIO6_BIT_MUX_BUS]))
    else $error("bus style select not taken");

  chk_dir_write_only: assert property (
    bus_req_in.rd && bus_req_in.addr == PIO6_OFF_DIR |=> rdata_out == PIO6_RST_BYTE)
    else $error("direction register readable");

  chk_filter_load: assert property (
    sample_load != PIO6_RST_BYTE && !wr_data |=> ((port_output_data ^ $past(filt_sample)) & $past(sample_load)) == 8'h00)
    else $error("filtered sample not stored");

  chk_tick_fast: assert property (
    tick && filter_interval_select == PIO6_SEL_D2 && !wr_filt_sel ##1 !wr_filt_sel |-> !tick ##1 tick)
    else $error("fastest interval not two cycles");

  chk_sync_depth: assert property (
    past_valid && $past(past_valid) |-> pin_level == $past(pin_in, 2))
    else $error("pin level not two flops late");

  cov_bus_mode_read: cover property (
    bus_req_in.rd && bus_req_in.addr == PIO6_OFF_DATA && ext16_mode_in);
  cov_filter_load: cover property (sample_load != PIO6_RST_BYTE);
  cov_pullup_write: cover property (wr_pullup ##1 pullup_on_out != PIO6_RST_BYTE);
endmodule

//--- pio6_pins_model.sv
// outside world at the port pins: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pio6_pins_model (
  input wire logic clk_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_b_in,
  input wire logic [7:0] pullup_on_in,
  input wire logic [7:0] drive_val_in,
  input wire logic [7:0] drive_en_in,
  output logic [7:0] level_out
);
  // ==========================================
  // floating pins change every cycle
  logic [7:0] float_pat = 8'h5A;
  always @(posedge clk_in) begin
    float_pat <= ~float_pat;
  end
  // ==========================================
  // pin resolution, port drive wins
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_b_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else if (drive_en_in[i]) begin
        level_out[i] = drive_val_in[i];
      end else if (pullup_on_in[i]) begin
        level_out[i] = 1'b1;
      end else begin
        level_out[i] = float_pat[i];
      end
    end
  end
endmodule

//--- port6_io_with_pullups_test.sv
// self-checking bench for the eight-pin port
`timescale 1ns/1ps
module port6_io_with_pullups_test;
  import pio6_pkg::*;
  logic clk_in, rst_b_in, ext16, kwe, ebd, pcs, mux;
  logic rd_seen = 1'b0;
  pio6_bus_req_t bus;
  logic [7:0] rdata, ebw, ebr, lvl, po, oe_b, pu, dval, den;
  logic [7:0] d, v, x, p, w, f, dat;
  logic [7:0] sc [4] = '{8'h20, 8'h08, 8'h28, 8'h00};
  logic [7:0] exp_q [$];
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  pio6_port #(.DIV_8192(16), .DIV_32768(64)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_req_in(bus),
    .rdata_out(rdata), .ext16_mode_in(ext16), .keyboard_wakeup_enable_in(kwe), .ext_bus_wdata_in(ebw),
    .ext_bus_drive_in(ebd), .ext_bus_rdata_out(ebr), .pin_in(lvl), .pin_out(po), .pin_oe_b_out(oe_b),
    .pullup_on_out(pu), .pullup_current_select_out(pcs), .muxed_bus_enable_out(mux));
  pio6_pins_model pins (.clk_in(clk_in), .pin_out_in(po), .pin_oe_b_in(oe_b), .pullup_on_in(pu),
    .drive_val_in(dval), .drive_en_in(den), .level_out(lvl));
  // ==========================================
  // clock, timeout and shared tasks
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dw);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: dw, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(exp);
    @(posedge clk_in);
    bus <= '0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // ==========================================
  // read data monitor, one cycle after each read
  always @(posedge clk_in) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
    rd_seen <= bus.rd;
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(85539));
    rst_b_in = 1'b0;
    bus = '0;
    ext16 = 1'b0;
    kwe = 1'b0;
    ebw = 8'h00;
    ebd = 1'b0;
    dval = 8'h00;
    den = 8'hFF;
    idle(12);
    rst_b_in <= 1'b1;
    rd(PIO6_OFF_DIR, 8'h00);
    rd(PIO6_OFF_DATA, 8'h00);
    rd(PIO6_OFF_SYSCTL2, 8'h00);
    idle(2);
    check(oe_b, 8'hFF);
    $display("test reset done");
    d = 8'($urandom);
    v = 8'($urandom);
    x = 8'($urandom);
    dval <= x;
    den <= ~d;
    wr(PIO6_OFF_DIR, d);
    wr(PIO6_OFF_DATA, v);
    idle(4);
    check(oe_b, ~d);
    check(po & d, v & d);
    rd(PIO6_OFF_DATA, (v & d) | (x & ~d));
    rd(PIO6_OFF_DIR, 8'h00);
    rd(3'h6, 8'h00);
    wr(3'h7, 8'hFF);
    $display("test direction and data done");
    p = 8'($urandom);
    wr(PIO6_OFF_PULLUP, 8'hFF);
    rd(PIO6_OFF_PULLUP, 8'h00);
    kwe <= 1'b1;
    den <= 8'h00;
    wr(PIO6_OFF_PULLUP, p);
    rd(PIO6_OFF_PULLUP, p);
    idle(4);
    check(pu, p & ~d);
    check(oe_b, ~d);
    $display("test pull-ups done");
    foreach (sc[i]) begin
      wr(PIO6_OFF_SYSCTL2, sc[i]);
      idle(2);
      check({7'h00, pcs}, {7'h00, sc[i][PIO6_BIT_PU_CURRENT]});
      check({7'h00, mux}, {7'h00, sc[i][PIO6_BIT_MUX_BUS]});
      rd(PIO6_OFF_SYSCTL2, sc[i]);
    end
    $display("test system control done");
    w = 8'($urandom);
    ext16 <= 1'b1;
    ebw <= w;
    ebd <= 1'b1;
    idle(5);
    check(oe_b, 8'h00);
    check(po, w);
    check(pu, 8'h00);
    check(ebr, w);
    rd(PIO6_OFF_DATA, (v & d) | ~d);
    x = 8'($urandom);
    ebd <= 1'b0;
    den <= 8'hFF;
    dval <= x;
    idle(5);
    check(oe_b, 8'hFF);
    check(ebr, x);
    ext16 <= 1'b0;
    $display("test wide bus done");
    dat = v;
    wr(PIO6_OFF_DIR, 8'h00);
    for (int c = 0; c < 5; c++) begin
      w = 8'($urandom);
      f = 8'($urandom);
      dval <= w;
      wr(PIO6_OFF_FILT_SEL, 8'(c));
      wr(PIO6_OFF_FILT_EN, f);
      idle(250);
      wr(PIO6_OFF_FILT_EN, 8'h00);
      dat = (w & f) | (dat & ~f);
      wr(PIO6_OFF_DIR, 8'hFF);
      rd(PIO6_OFF_DATA, dat);
      wr(PIO6_OFF_DIR, 8'h00);
    end
    $display("test input filter done");
    idle(3);
    results();
  end
endmodule
